//--- core/stwp_top.sv
// Shared timer/watchdog divider: configuration, routing and clears.
// Assumes the core supplies one-cycle strobes per instruction cycle.
// Functional notes
// - One 8-bit divider, prescaler for timer or postscaler for watchdog.
// - Divider serves one user; the other runs undivided.
// - Assignment bit and 3-bit ratio in config bits 3..0 pick user and ratio.
// - Timer-assigned: any timer count write clears the divider.
// - Watchdog-assigned: watchdog-clear clears watchdog counter and divider.
// - Divider count has no read or write path.
// - Any reset forces the divider to zero.
// - Assignment may change any time without halting timer or watchdog.
// - Config bit 3: 0 selects timer, 1 selects watchdog.
// - Ratios are powers of two from 1 to 256.
// - Config: bit5 source, bit4 edge, bit3 assign, bits2..0 ratio; reset 111111.
// - External count pin is the alternative timer clock source.
`timescale 1ns/1ps
module stwp_top (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_instr_tick,
	input wire logic i_wdt_tick,
	input wire logic i_ext_count_clk,
	input wire logic i_cfg_wr,
	input wire logic [stwp_pkg::STWP_CFG_W-1:0] i_cfg_data,
	input wire logic i_timer_count_wr,
	input wire logic i_watchdog_clear_instr,
	output logic [stwp_pkg::STWP_CFG_W-1:0] o_cfg,
	output logic o_timer_inc,
	output logic o_wdt_inc,
	output logic o_wdt_clear
);
	import stwp_pkg::*;

	stwp_tick_if tick_bus ();

	logic [STWP_CFG_W-1:0] cfg_ff;
	logic [STWP_SYNC_STAGES-1:0] ext_sync_ff;
	logic ext_level_ff;
	logic ext_edge;
	logic tmr_src_tick;
	logic scaler_assign_sel;
	logic [STWP_RATIO_W-1:0] scaler_ratio_sel;
	logic count_source_sel;
	logic count_edge_sel;
	logic timer_inc_ff;
	logic wdt_inc_ff;
	logic wdt_clear_ff;
	stwp_user_t user;

	// Config register, reset value 111111
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cfg_ff <= STWP_CFG_RST;
		end else if (i_cfg_wr) begin
			cfg_ff <= i_cfg_data;
		end
	end

	assign scaler_ratio_sel = cfg_ff[STWP_RATIO_LSB +: STWP_RATIO_W];
	assign scaler_assign_sel = cfg_ff[STWP_ASSIGN_BIT];
	assign count_edge_sel = cfg_ff[STWP_EDGE_BIT];
	assign count_source_sel = cfg_ff[STWP_SRC_BIT];
	assign user = scaler_assign_sel ? STWP_USER_WDT : STWP_USER_TMR;

	// Three-stage synchroniser; only stages two and three are compared
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ext_sync_ff <= '0;
			ext_level_ff <= 1'b0;
		end else begin
			ext_sync_ff <= {ext_sync_ff[1:0], i_ext_count_clk};
			if (ext_sync_ff[1] == ext_sync_ff[2]) begin
				ext_level_ff <= ext_sync_ff[2];
			end
		end
	end

	// Edge select: 0 counts rising, 1 counts falling
	assign ext_edge = (ext_sync_ff[1] == ext_sync_ff[2]) && (ext_sync_ff[2] != ext_level_ff)
		&& (ext_sync_ff[2] == ~count_edge_sel);
	assign tmr_src_tick = count_source_sel ? ext_edge : i_instr_tick;

	// Routing follows the live config bit, so a switch takes effect next cycle
	always_comb begin
		tick_bus.tmr_mode = 1'b1;
		tick_bus.tick_in = 1'b0;
		tick_bus.clear = 1'b0;
		case (user)
			STWP_USER_TMR: begin
				tick_bus.tmr_mode = 1'b1;
				tick_bus.tick_in = tmr_src_tick;
				tick_bus.clear = i_timer_count_wr;
			end
			STWP_USER_WDT: begin
				tick_bus.tmr_mode = 1'b0;
				tick_bus.tick_in = i_wdt_tick;
				tick_bus.clear = i_watchdog_clear_instr;
			end
			default: begin
				tick_bus.tmr_mode = 1'b1;
				tick_bus.tick_in = 1'b0;
				tick_bus.clear = 1'b0;
			end
		endcase
	end
	assign tick_bus.ratio = scaler_ratio_sel;

	stwp_divider u_div (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.bus(tick_bus.div)
	);

	// Unassigned user bypasses the divider entirely
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			timer_inc_ff <= 1'b0;
			wdt_inc_ff <= 1'b0;
		end else begin
			timer_inc_ff <= scaler_assign_sel ? tmr_src_tick : tick_bus.tick_out;
			wdt_inc_ff <= scaler_assign_sel ? tick_bus.tick_out : i_wdt_tick;
		end
	end

	// Watchdog-clear always resets the watchdog counter itself
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			wdt_clear_ff <= 1'b0;
		end else begin
			wdt_clear_ff <= i_watchdog_clear_instr;
		end
	end

	assign o_cfg = cfg_ff;
	assign o_timer_inc = timer_inc_ff;
	assign o_wdt_inc = wdt_inc_ff;
	assign o_wdt_clear = wdt_clear_ff;
endmodule : stwp_top

//--- core/stwp_pkg.sv
// Package for the shared timer/watchdog divider block.
// Assumes a single 40 MHz system clock and an active-low asynchronous reset.
package stwp_pkg;
	localparam int STWP_DIV_W = 8;
	localparam int STWP_CFG_W = 6;
	localparam int STWP_RATIO_LSB = 0;
	localparam int STWP_RATIO_W = 3;
	localparam int STWP_ASSIGN_BIT = 3;
	localparam int STWP_EDGE_BIT = 4;
	localparam int STWP_SRC_BIT = 5;
	localparam logic [STWP_CFG_W-1:0] STWP_CFG_RST = 6'h3f;
	localparam logic [STWP_DIV_W-1:0] STWP_DIV_RST = 8'h00;
	localparam real STWP_CLK_MHZ = 40.0;
	localparam int STWP_SYNC_STAGES = 3;

	typedef enum logic [1:0] {
		STWP_USER_TMR = 2'b01,
		STWP_USER_WDT = 2'b10
	} stwp_user_t;
endpackage : stwp_pkg

//--- core/stwp_tick_if.sv
// Interface carrying the divider's input tick and tapped output between modules.
// Assumes both ends sit on the same system clock.
`timescale 1ns/1ps
interface stwp_tick_if;
	logic tick_in;
	logic clear;
	logic [2:0] ratio;
	logic tmr_mode;
	logic tick_out;
	modport ctrl (output tick_in, output clear, output ratio, output tmr_mode, input tick_out);
	modport div (input tick_in, input clear, input ratio, input tmr_mode, output tick_out);
endinterface : stwp_tick_if

//--- core/stwp_divider.sv
// Eight-bit ripple-free divider counter with tap multiplexer.
// Assumes tick_in is a one-cycle enable pulse on the system clock.
`timescale 1ns/1ps
module stwp_divider (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	stwp_tick_if.div bus
);
	import stwp_pkg::*;

	logic [STWP_DIV_W-1:0] cnt_ff;
	logic [STWP_DIV_W-1:0] nxt_cnt;
	logic [STWP_DIV_W:0] carry;

	// Counter is never loaded from outside; only ticks, clear and reset change it
	always_comb begin
		nxt_cnt = cnt_ff + 8'h01;
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_ff <= STWP_DIV_RST;
		end else if (bus.clear) begin
			cnt_ff <= STWP_DIV_RST;
		end else if (bus.tick_in) begin
			cnt_ff <= nxt_cnt;
		end
	end

	// carry[k] pulses once every 2^k input ticks
	// A clear in the same cycle swallows the tick, so no stale carry escapes
	assign carry[0] = bus.tick_in & ~bus.clear;
	genvar k;
	generate
		for (k = 0; k < STWP_DIV_W; k++) begin : g_carry
			assign carry[k+1] = carry[k] & (&cnt_ff[k:0]);
		end
	endgenerate

	// Timer taps 2^(n+1), watchdog taps 2^n, so 1..256 overall
	assign bus.tick_out = bus.tmr_mode ? carry[bus.ratio + 4'd1] : carry[bus.ratio];
endmodule : stwp_divider

//--- sim/stwp_top_sva.sv
// Port checker for the shared divider.
// Assumes one clock, async low reset.
`timescale 1ns/1ps
module stwp_chk (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_instr_tick,
	input wire logic i_wdt_tick,
	input wire logic i_cfg_wr,
	input wire logic [stwp_pkg::STWP_CFG_W-1:0] i_cfg_data,
	input wire logic i_timer_count_wr,
	input wire logic i_watchdog_clear_instr,
	input wire logic [stwp_pkg::STWP_CFG_W-1:0] o_cfg,
	input wire logic o_timer_inc,
	input wire logic o_wdt_inc,
	input wire logic o_wdt_clear
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	property p_cfg; i_cfg_wr |=> o_cfg == $past(i_cfg_data); endproperty
	a_cfg: assert property (p_cfg) else $error("cfg");
	property p_hold; !i_cfg_wr |=> $stable(o_cfg); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_wclr; i_watchdog_clear_instr |=> o_wdt_clear; endproperty
	a_wclr: assert property (p_wclr) else $error("wclr");
	property p_nclr; !i_watchdog_clear_instr |=> !o_wdt_clear; endproperty
	a_nclr: assert property (p_nclr) else $error("nclr");
	// Clear and tick together: the clear wins, so no carry may come out
	sequence s_tclr; !o_cfg[5] && !o_cfg[3] && i_timer_count_wr && i_instr_tick; endsequence
	property p_tclr; s_tclr |=> !o_timer_inc; endproperty
	a_tclr: assert property (p_tclr) else $error("tclr");
	property p_tpass; o_cfg[3] && !o_cfg[5] && i_instr_tick |=> o_timer_inc; endproperty
	a_tpass: assert property (p_tpass) else $error("tpass");
	property p_wpass; !o_cfg[3] && i_wdt_tick |=> o_wdt_inc; endproperty
	a_wpass: assert property (p_wpass) else $error("wpass");
	property p_tdiv; o_cfg == 0 && $stable(o_cfg) && o_timer_inc |=> !o_timer_inc; endproperty
	a_tdiv: assert property (p_tdiv) else $error("tdiv");
endmodule : stwp_chk
bind stwp_top stwp_chk u_chk (
	.i_clk_sys(i_clk_sys),
	.i_rstn(i_rstn),
	.i_instr_tick(i_instr_tick),
	.i_wdt_tick(i_wdt_tick),
	.i_cfg_wr(i_cfg_wr),
	.i_cfg_data(i_cfg_data),
	.i_timer_count_wr(i_timer_count_wr),
	.i_watchdog_clear_instr(i_watchdog_clear_instr),
	.o_cfg(o_cfg),
	.o_timer_inc(o_timer_inc),
	.o_wdt_inc(o_wdt_inc),
	.o_wdt_clear(o_wdt_clear)
);

//--- sim/stwp_core_model.sv
// Core model: paces instruction and watchdog ticks.
// Assumes GAP cycles per tick; 1 is a full-speed core.
`timescale 1ns/1ps
module stwp_core_model #(parameter int GAP = 1) (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	output logic o_tick
);
	int cnt_ff;
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) cnt_ff <= 0;
		else cnt_ff <= (cnt_ff + 1) % GAP;
	end
	// Silent in reset, so no strobe lands before the first legal edge
	assign o_tick = i_rstn && cnt_ff == 0;
endmodule : stwp_core_model

//--- sim/tb_top.sv
// Bench: every ratio for both users, counting increments.
// Assumes the core model ticks every cycle.
`timescale 1ns/1ps
module tb_top;
	import stwp_pkg::*;
	logic i_clk_sys = 0, i_rstn = 0, i_cfg_wr = 0, i_timer_count_wr = 0;
	logic i_watchdog_clear_instr = 0, i_ext_count_clk = 0, en = 0;
	logic [STWP_CFG_W-1:0] i_cfg_data = '0, o_cfg;
	logic i_instr_tick, i_wdt_tick, o_timer_inc, o_wdt_inc, o_wdt_clear;
	logic [31:0] tcnt, wcnt;
	int err_total = 0, checks_done = 0, cyc = 0;
	assign i_wdt_tick = i_instr_tick;
	always #12.5 i_clk_sys = ~i_clk_sys;
	stwp_core_model u_core (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.o_tick(i_instr_tick)
	);
	stwp_top u_dut (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_instr_tick(i_instr_tick),
		.i_wdt_tick(i_wdt_tick),
		.i_ext_count_clk(i_ext_count_clk),
		.i_cfg_wr(i_cfg_wr),
		.i_cfg_data(i_cfg_data),
		.i_timer_count_wr(i_timer_count_wr),
		.i_watchdog_clear_instr(i_watchdog_clear_instr),
		.o_cfg(o_cfg),
		.o_timer_inc(o_timer_inc),
		.o_wdt_inc(o_wdt_inc),
		.o_wdt_clear(o_wdt_clear)
	);
	always @(posedge i_clk_sys) begin
		tcnt <= en ? tcnt + o_timer_inc : 0;
		wcnt <= en ? wcnt + o_wdt_inc : 0;
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			err_total++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim();
		if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	task automatic clr();
		@(posedge i_clk_sys);
		i_timer_count_wr <= 1'h1;
		i_watchdog_clear_instr <= 1'h1;
		@(posedge i_clk_sys);
		i_timer_count_wr <= 1'h0;
		i_watchdog_clear_instr <= 1'h0;
	endtask : clr
	// 511 ticks from a cleared divider: a count that was not cleared shows up
	task automatic run(input logic [3:0] c);
		logic [3:0] k;
		k = c[2:0] + {3'h0, ~c[3]};
		clr();
		i_cfg_wr <= 1'h1;
		i_cfg_data <= {2'h0, c};
		@(posedge i_clk_sys);
		i_cfg_wr <= 1'h0;
		clr();
		@(negedge i_clk_sys);
		chk(o_wdt_clear, 1);
		chk(o_cfg, c);
		@(posedge i_clk_sys);
		en <= 1'h1;
		// The other user's clear strobe must leave the divider alone
		for (int i = 0; i < 511; i++) begin
			@(posedge i_clk_sys);
			i_timer_count_wr <= c[3] && (i % 37 == 20);
			i_watchdog_clear_instr <= !c[3] && (i % 37 == 20);
		end
		@(negedge i_clk_sys);
		chk(tcnt, c[3] ? 511 : 511 >> k);
		chk(wcnt, c[3] ? 511 >> c[2:0] : 511);
		en <= 1'h0;
	endtask : run
	// Seven pin toggles give three edges of the selected kind and four of the other
	task automatic ext(input logic e);
		@(posedge i_clk_sys);
		i_cfg_wr <= 1'h1;
		i_cfg_data <= {1'h1, e, 4'h8};
		@(posedge i_clk_sys);
		i_cfg_wr <= 1'h0;
		@(posedge i_clk_sys);
		en <= 1'h1;
		repeat (7) begin
			repeat (4) @(posedge i_clk_sys);
			i_ext_count_clk <= ~i_ext_count_clk;
		end
		repeat (6) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		chk(tcnt, 3);
		en <= 1'h0;
	endtask : ext
	initial begin
		repeat (8) @(posedge i_clk_sys);
		chk(o_cfg, STWP_CFG_RST);
		chk(o_timer_inc, 0);
		i_rstn <= 1'h1;
		for (int a = 0; a < 16; a++)
			run(a[3:0]);
		ext(1'h1);
		ext(1'h0);
		// Mid-run reset: a divider left non-zero would carry before 128 ticks
		@(posedge i_clk_sys);
		i_rstn <= 1'h0;
		repeat (2) @(posedge i_clk_sys);
		chk(o_cfg, STWP_CFG_RST);
		i_rstn <= 1'h1;
		en <= 1'h1;
		repeat (128) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		chk(wcnt, 0);
		@(posedge i_clk_sys);
		@(negedge i_clk_sys);
		chk(wcnt, 1);
		end_sim();
	end
endmodule : tb_top
